// file: core/rdo_pkg.sv
// Package for the resolver angle output and configuration block.
// Assumes a single 250 MHz clock and synchronous active-high reset.
package rdo_pkg;
    localparam int RDO_CLK_MHZ = 250;
    localparam int RDO_FOLLOW_FAST_MS = 20;
    localparam int RDO_FOLLOW_SLOW_MS = 100;
    localparam int RDO_FOLLOW_FAST_CYC = RDO_FOLLOW_FAST_MS * 1000 * RDO_CLK_MHZ;
    localparam int RDO_FOLLOW_SLOW_CYC = RDO_FOLLOW_SLOW_MS * 1000 * RDO_CLK_MHZ;
    localparam int RDO_ANGLE_W = 12;
    localparam int RDO_SER_MSB = 11;
    localparam logic [11:0] RDO_ANGLE_RST = 12'h000;
    localparam logic [1:0] RDO_RES_12 = 2'h0;
    localparam logic [1:0] RDO_RES_10 = 2'h1;

    typedef struct packed {
        logic resolution_select;
        logic pole_scale_select_lo;
        logic pole_scale_select_hi;
        logic excite_freq_select_lo;
        logic excite_freq_select_hi;
        logic accel_mode_enable;
    } rdo_cfg_type;

    typedef struct packed {
        logic serial_select_n;
        logic serial_clk;
    } rdo_ser_type;

    typedef enum logic [2:0] {
        RDO_ST_FOLLOW = 3'b001,
        RDO_ST_IDLE = 3'b010,
        RDO_ST_SHIFT = 3'b100
    } rdo_ser_state_type;
endpackage : rdo_pkg

// file: core/rdo_angle_output.sv
// Angle output logic: parallel word, serial shift port, A/B pulses.
// Assumes tracked angle and test register arrive synchronous to clk;
// config pins are static; serial clock is sampled as a plain input.
// Serial clock must hold each level for at least one clk period.
// Follow-up counts are parameters so a bench can shorten them.
//
// Behaviour
// - Only 12-bit and 10-bit resolutions exist; 10-bit zeroes two LSBs.
// - Resolution select high at reset release gives 10 bits, else 12.
// - Raising serial select early refreshes data; next read starts at MSB.
// - Serial and parallel outputs work independently of each other.
// - Pole scale inputs never change the parallel absolute angle.
// - Both frequency selects low put the test register on the parallel word.
// - Initial follow-up lasts 100 ms without, 20 ms with acceleration mode.
// - A/B quadrature pulses follow the tracked angle; duty may be irregular.
`timescale 1ns/1ps
`default_nettype none
module rdo_angle_output import rdo_pkg::*; #(
    parameter int FOLLOW_FAST_CYC = RDO_FOLLOW_FAST_CYC,
    parameter int FOLLOW_SLOW_CYC = RDO_FOLLOW_SLOW_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire rdo_cfg_type cfg,
    input wire rdo_ser_type ser,
    input wire logic [11:0] tracked_angle,
    input wire logic [11:0] internal_op_register,
    output logic [11:0] parallel_angle_word,
    output logic serial_data_out,
    output logic enc_a,
    output logic enc_b,
    output logic follow_done,
    output logic internal_velocity_test,
    output logic ten_bit_mode
);
    logic res10_ff;
    logic strap_taken_ff;
    logic [31:0] follow_cnt_ff;
    logic follow_done_ff;
    logic [11:0] par_ff;
    logic vel_test_ff;
    rdo_ser_state_type ser_st_ff;
    logic [11:0] shreg_ff;
    logic sck_d_ff;
    logic sdo_ff;
    logic enc_a_ff;
    logic enc_b_ff;
    logic [11:0] masked;
    logic sck_rise;
    logic read_start;
    logic shifting;

    function automatic logic [11:0] res_mask(input logic [11:0] a,
                                             input logic r10);
        res_mask = r10 ? {a[11:2], 2'h0} : a;
    endfunction : res_mask

    // One quadrature cycle per four counts of the lowest active bit pair
    function automatic logic [1:0] quad_ab(input logic [1:0] pair);
        quad_ab = {pair[1], pair[1] ^ pair[0]};
    endfunction : quad_ab

    // Both frequency selects low is the factory velocity test setting
    function automatic logic test_setting(input rdo_cfg_type c);
        test_setting = !c.excite_freq_select_lo && !c.excite_freq_select_hi;
    endfunction : test_setting

    function automatic logic [31:0] follow_limit(input logic accel);
        if (accel) begin
            follow_limit = 32'(FOLLOW_FAST_CYC - 1);
        end else begin
            follow_limit = 32'(FOLLOW_SLOW_CYC - 1);
        end
    endfunction : follow_limit

    assign masked = res_mask(tracked_angle, res10_ff);

    // Strap caught by a clocked process right after reset release
    always_ff @(posedge clk) begin
        if (reset) begin
            res10_ff <= 1'b0;
            strap_taken_ff <= 1'b0;
        end else if (!strap_taken_ff) begin
            res10_ff <= cfg.resolution_select;
            strap_taken_ff <= 1'b1;
        end else if (follow_done_ff) begin
            // Later change allowed once follow-up is complete
            res10_ff <= cfg.resolution_select;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            follow_cnt_ff <= 32'h00000000;
        end else if (!follow_done_ff) begin
            follow_cnt_ff <= follow_cnt_ff + 32'h00000001;
        end
    end

    // Acceleration is read live, so a late change moves the deadline
    always_ff @(posedge clk) begin
        if (reset) begin
            follow_done_ff <= 1'b0;
        end else if (!follow_done_ff) begin
            if (follow_cnt_ff >= follow_limit(cfg.accel_mode_enable)) begin
                follow_done_ff <= 1'b1;
            end
        end
    end

    // Pole scale pins are deliberately not read here
    always_ff @(posedge clk) begin
        if (reset) begin
            par_ff <= RDO_ANGLE_RST;
        end else if (test_setting(cfg)) begin
            par_ff <= internal_op_register;
        end else begin
            par_ff <= masked;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            vel_test_ff <= 1'b0;
        end else begin
            vel_test_ff <= test_setting(cfg);
        end
    end

    // Serial clock edge is seen as sampled low, then high on the next edge
    always_ff @(posedge clk) begin
        if (reset) begin
            sck_d_ff <= 1'b0;
        end else begin
            sck_d_ff <= ser.serial_clk;
        end
    end

    // Edge decode shared by the snapshot and the data bit; start and shift decodes feed only the data bit
    assign sck_rise = ser.serial_clk && !sck_d_ff;
    assign read_start = !ser.serial_select_n &&
                        (ser_st_ff == RDO_ST_FOLLOW || ser_st_ff == RDO_ST_IDLE);
    assign shifting = !ser.serial_select_n && (ser_st_ff == RDO_ST_SHIFT);

    // Serial side keeps its own snapshot so the parallel path never waits
    always_ff @(posedge clk) begin
        if (reset) begin
            ser_st_ff <= RDO_ST_FOLLOW;
        end else begin
            case (ser_st_ff)
                RDO_ST_FOLLOW: begin
                    if (!ser.serial_select_n) begin
                        ser_st_ff <= RDO_ST_SHIFT;
                    end else begin
                        ser_st_ff <= RDO_ST_IDLE;
                    end
                end
                RDO_ST_IDLE: begin
                    if (!ser.serial_select_n) begin
                        ser_st_ff <= RDO_ST_SHIFT;
                    end
                end
                RDO_ST_SHIFT: begin
                    if (ser.serial_select_n) begin
                        ser_st_ff <= RDO_ST_IDLE;
                    end
                end
                default: begin
                    ser_st_ff <= RDO_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            shreg_ff <= RDO_ANGLE_RST;
        end else if (ser_st_ff != RDO_ST_SHIFT) begin
            shreg_ff <= masked;
        end else if (ser.serial_select_n) begin
            shreg_ff <= masked;
        end else if (sck_rise) begin
            shreg_ff <= {shreg_ff[10:0], 1'b0};
        end
    end

    // Data bit holds its last value while deselected; the host ignores it
    always_ff @(posedge clk) begin
        if (reset) begin
            sdo_ff <= 1'b0;
        end else if (read_start) begin
            sdo_ff <= masked[RDO_SER_MSB];
        end else if (shifting && sck_rise) begin
            sdo_ff <= shreg_ff[RDO_SER_MSB - 1];
        end
    end

    // Quadrature from the two lowest active bits; duty follows the tracker
    always_ff @(posedge clk) begin
        if (reset) begin
            enc_a_ff <= 1'b0;
            enc_b_ff <= 1'b0;
        end else if (res10_ff) begin
            {enc_b_ff, enc_a_ff} <= quad_ab(tracked_angle[3:2]);
        end else begin
            {enc_b_ff, enc_a_ff} <= quad_ab(tracked_angle[1:0]);
        end
    end

    // Every output is a flop; nothing combinational leaves the block
    assign parallel_angle_word = par_ff;
    assign serial_data_out = sdo_ff;
    assign enc_a = enc_a_ff;
    assign enc_b = enc_b_ff;
    assign follow_done = follow_done_ff;
    assign internal_velocity_test = vel_test_ff;
    assign ten_bit_mode = res10_ff;
endmodule : rdo_angle_output
`default_nettype wire

// file: tb/rdo_angle_output_asserts.sv
// Port checker for the angle output block.
// Bound to the design; sees its pins only.
`timescale 1ns/1ps
`default_nettype none
module rdo_angle_output_asserts import rdo_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire rdo_cfg_type cfg,
    input wire rdo_ser_type ser,
    input wire logic [11:0] tracked_angle,
    input wire logic [11:0] internal_op_register,
    input wire logic [11:0] parallel_angle_word,
    input wire logic serial_data_out,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic follow_done,
    input wire logic internal_velocity_test,
    input wire logic ten_bit_mode
);
    logic [1:0] rst_ff;
    always_ff @(posedge clk) rst_ff <= {rst_ff[0], reset};
    // Outputs stay cleared just after reset, so skip those edges
    wire logic up = ~|rst_ff;
    wire logic nv = cfg.excite_freq_select_lo | cfg.excite_freq_select_hi;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_TW: assert property (up && !nv |=> internal_velocity_test
        && parallel_angle_word == $past(internal_op_register)) else $error("tw");
    AST_P10: assert property (up && nv && ten_bit_mode |=>
        parallel_angle_word == {$past(tracked_angle[11:2]), 2'h0}) else $error("p10");
    AST_P12: assert property (up && nv && !ten_bit_mode |=>
        parallel_angle_word == $past(tracked_angle)) else $error("p12");
    AST_ENC: assert property (up && !ten_bit_mode |=>
        enc_b == $past(tracked_angle[1]) && enc_a == ^$past(tracked_angle[1:0]))
        else $error("enc");
    AST_ENC10: assert property (up && ten_bit_mode |=>
        enc_b == $past(tracked_angle[3]) &&
        enc_a == ^$past(tracked_angle[3:2])) else $error("enc10");
    AST_SDO: assert property (up && !$rose(ser.serial_clk) &&
        !$fell(ser.serial_select_n) |=> $stable(serial_data_out)) else $error("sdo");
    AST_MSB: assert property (up && $fell(ser.serial_select_n) |=>
        serial_data_out == $past(tracked_angle[11])) else $error("msb");
    AST_STRAP: assert property ($fell(reset) |=> ##1
        ten_bit_mode == $past(cfg.resolution_select, 2)) else $error("strap");
    AST_HOLD: assert property (up && !follow_done |=>
        $stable(ten_bit_mode)) else $error("mode");
    cover property (internal_velocity_test);
    cover property ($fell(ser.serial_select_n));
    cover property ($rose(follow_done));
endmodule : rdo_angle_output_asserts
`default_nettype wire

// file: tb/rdo_host_model.sv
// Host model reading the serial angle port.
// Assumes serial data is registered on clk; drives ser after each edge.
`timescale 1ns/1ps
`default_nettype none
module rdo_host_model import rdo_pkg::*; (
    input wire logic clk,
    input wire logic sdo,
    output var rdo_ser_type ser
);
    initial ser = 2'h2;
    task automatic rd(input int n, output logic [11:0] w);
        w = 12'h000;
        ser.serial_select_n <= 1'b0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            w[11 - i] = sdo;
            ser.serial_clk <= 1'b1;
            repeat (2) @(posedge clk);
            ser.serial_clk <= 1'b0;
            repeat (2) @(posedge clk);
        end
        ser.serial_select_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : rd
endmodule : rdo_host_model
`default_nettype wire

// file: tb/tb_rdo_angle_output.sv
// Bench: random angles and pins, serial reads through the host model.
// Assumes short follow-up counts set by parameter.
`timescale 1ns/1ps
`default_nettype none
module tb_rdo_angle_output import rdo_pkg::*;;
    logic clk = 1'b0;
    logic reset = 1'b1;
    rdo_cfg_type cfg = 6'h07;
    rdo_ser_type ser;
    logic [11:0] ang = 12'h000;
    logic [11:0] opr = 12'h000;
    logic [11:0] par, w;
    logic sdo, ten, fd;
    logic ea, eb, vt;
    int failures = 0;
    int compares = 0;
    always #2 clk = ~clk;
    rdo_angle_output #(.FOLLOW_FAST_CYC(20), .FOLLOW_SLOW_CYC(100)) dut (
        .clk(clk), .reset(reset), .cfg(cfg), .ser(ser), .tracked_angle(ang),
        .internal_op_register(opr), .parallel_angle_word(par),
        .serial_data_out(sdo), .enc_a(ea), .enc_b(eb), .follow_done(fd),
        .internal_velocity_test(vt), .ten_bit_mode(ten));
    rdo_host_model host (.clk(clk), .sdo(sdo), .ser(ser));
    function automatic logic [11:0] exp_word(input logic [11:0] a, o,
            input logic v, t);
        return v ? o : (t ? {a[11:2], 2'h0} : a);
    endfunction : exp_word
    function automatic logic [11:0] exp_enc(input logic [11:0] a,
            input logic t);
        logic [1:0] p;
        p = t ? a[3:2] : a[1:0];
        return {10'h000, p[1], p[1] ^ p[0]};
    endfunction : exp_enc
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("Compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin
        #40000;
        failures++;
        stop_test;
    end
    initial begin
        void'($urandom(75831));
        for (int k = 0; k < 2; k++) begin
            reset <= 1'b1;
            cfg.accel_mode_enable <= (k == 0);
            cfg.resolution_select <= (k == 1);
            repeat (12) @(posedge clk);
            reset <= 1'b0;
            repeat ((k == 0 ? 20 : 100) - 2) @(posedge clk);
            chk({11'h0, fd}, 12'h000);
            repeat (5) @(posedge clk);
            chk({11'h0, fd}, 12'h001);
            chk({11'h0, ten}, {11'h0, k == 1});
            cfg.resolution_select <= 1'b1;
            repeat (3) @(posedge clk);
            chk({11'h0, ten}, 12'h001);
            for (int i = 0; i < 20; i++) begin
                ang <= (i == 0) ? 12'hFFF : 12'($urandom);
                opr <= 12'($urandom);
                cfg[5:1] <= 5'($urandom);
                // Mode flop, then output flop; the third edge is margin
                repeat (3) @(posedge clk);
                chk(par, exp_word(ang, opr, !(cfg.excite_freq_select_lo |
                    cfg.excite_freq_select_hi), cfg.resolution_select));
                chk({10'h000, eb, ea}, exp_enc(ang, cfg.resolution_select));
                chk({11'h000, vt}, {11'h000, !(cfg.excite_freq_select_lo |
                    cfg.excite_freq_select_hi)});
                host.rd(i % 2 ? 8 : 12, w);
                chk(w, exp_word(ang, opr, 1'b0, cfg.resolution_select)
                    & (12'hFFF << (i % 2 ? 4 : 0)));
            end
        end
        stop_test;
    end
endmodule : tb_rdo_angle_output
bind rdo_angle_output rdo_angle_output_asserts chk_i (.*);
`default_nettype wire
